/* File: src/rcd_top.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// What this block does
// - enable bit seven runs or stops generator
// - output enable bit six drives pin in external mode with clock-out bit set
// - slew bit five limits pin slew rate
// - duty field selects 0/25/50/75 percent high
// - divider field divides by 1 to 128
// - undivided mode passes source duty, except zero
// - divide-by-two quarter duties use both edges
// - clock-out bit zero clear puts sysclk/4 on pin
// - system clock is the only source
// - any reset disables and restores defaults
// - crystal modes keep pin undriven
// - sleep holds outputs at current level
module rcd_top (
   // clock and reset
   input  wire logic                        SYS_CLK_I,
   input  wire logic                        NRST_I,
   // axi4-lite write address
   input  wire logic [rcd_pkg::ADDR_W-1:0]  S_AXI_AWADDR_I,
   input  wire logic                        S_AXI_AWVALID_I,
   output logic                             S_AXI_AWREADY_O,
   // axi4-lite write data
   input  wire logic [rcd_pkg::DATA_W-1:0]  S_AXI_WDATA_I,
   input  wire logic [3:0]                  S_AXI_WSTRB_I,
   input  wire logic                        S_AXI_WVALID_I,
   output logic                             S_AXI_WREADY_O,
   // axi4-lite write response
   output logic [1:0]                       S_AXI_BRESP_O,
   output logic                             S_AXI_BVALID_O,
   input  wire logic                        S_AXI_BREADY_I,
   // axi4-lite read address
   input  wire logic [rcd_pkg::ADDR_W-1:0]  S_AXI_ARADDR_I,
   input  wire logic                        S_AXI_ARVALID_I,
   output logic                             S_AXI_ARREADY_O,
   // axi4-lite read data
   output logic [rcd_pkg::DATA_W-1:0]       S_AXI_RDATA_O,
   output logic [1:0]                       S_AXI_RRESP_O,
   output logic                             S_AXI_RVALID_O,
   input  wire logic                        S_AXI_RREADY_I,
   // reference clock pin and modulator clock
   output logic                             REF_CLOCK_OUT_PIN_O,
   output logic                             REF_CLOCK_OUT_PIN_OE_O,
   output logic                             REFCLK_SLEW_LIMIT_ENABLE_O,
   output logic                             MOD_CLK_O
);
   import rcd_pkg::*;

   typedef struct packed {
      logic [7:0]             ctrl;
      logic [7:0]             cfg;
      logic [FOSC4_CNT_W-1:0] fosc_cnt;
      logic                   aw_got;
      logic [ADDR_W-1:0]      awaddr;
      logic                   w_got;
      logic [7:0]             wdata;
      logic                   wstb0;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [DATA_W-1:0]      rdata;
      logic [1:0]             rresp;
   } rcd_top_state_t;

   logic [1:0]     rst_sync_r;
   logic           rst_n;
   rcd_top_state_t st_r;
   rcd_top_state_t st_nxt;
   logic           aw_hs;
   logic           w_hs;
   logic           ar_hs;
   logic [1:0]     osc_mode;
   logic           sleep;
   logic           pin;
   logic           pin_oe;

   rcd_gen_if gif ();

   // reset release through two flops
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_r[1];

   assign S_AXI_AWREADY_O = !st_r.aw_got && !st_r.bvalid;
   assign S_AXI_WREADY_O  = !st_r.w_got && !st_r.bvalid;
   assign S_AXI_ARREADY_O = !st_r.rvalid;
   assign aw_hs           = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
   assign w_hs            = S_AXI_WVALID_I && S_AXI_WREADY_O;
   assign ar_hs           = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   assign osc_mode        = st_r.cfg[CFG_OSC_LSB +: 2];
   assign sleep           = st_r.cfg[CFG_SLEEP_BIT];

   always_comb begin
      st_nxt = st_r;
      if (!sleep) begin
         st_nxt.fosc_cnt = st_r.fosc_cnt + 2'h1;
      end
      if (aw_hs) begin
         st_nxt.aw_got = 1'h1;
         st_nxt.awaddr = S_AXI_AWADDR_I;
      end
      if (w_hs) begin
         st_nxt.w_got = 1'h1;
         st_nxt.wdata = S_AXI_WDATA_I[7:0];
         st_nxt.wstb0 = S_AXI_WSTRB_I[0];
      end
      // commit once both halves of the write are in
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'h0;
         st_nxt.w_got  = 1'h0;
         st_nxt.bvalid = 1'h1;
         st_nxt.bresp  = RESP_OKAY;
         case (st_r.awaddr)
            REG_CTRL_OFS: begin
               if (st_r.wstb0) begin
                  st_nxt.ctrl = st_r.wdata;
               end
            end
            REG_CFG_OFS: begin
               if (st_r.wstb0) begin
                  st_nxt.cfg = {4'h0, st_r.wdata[3:0]};
               end
            end
            REG_STAT_OFS: begin
               st_nxt.bresp = RESP_OKAY;
            end
            default: begin
               st_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && S_AXI_BREADY_I) begin
         st_nxt.bvalid = 1'h0;
      end
      if (st_r.rvalid && S_AXI_RREADY_I) begin
         st_nxt.rvalid = 1'h0;
      end
      if (ar_hs) begin
         st_nxt.rvalid = 1'h1;
         st_nxt.rresp  = RESP_OKAY;
         case (S_AXI_ARADDR_I)
            REG_CTRL_OFS: begin
               st_nxt.rdata = {24'h000000, st_r.ctrl};
            end
            REG_CFG_OFS: begin
               st_nxt.rdata = {24'h000000, st_r.cfg};
            end
            REG_STAT_OFS: begin
               st_nxt.rdata = {23'h000000, gif.count, gif.run, gif.level};
            end
            default: begin
               st_nxt.rdata = 32'h00000000;
               st_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= '0;
         st_r.ctrl <= CTRL_RST;
         st_r.cfg  <= CFG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign S_AXI_BVALID_O = st_r.bvalid;
   assign S_AXI_BRESP_O  = st_r.bresp;
   assign S_AXI_RVALID_O = st_r.rvalid;
   assign S_AXI_RDATA_O  = st_r.rdata;
   assign S_AXI_RRESP_O  = st_r.rresp;

   assign gif.enable   = st_r.ctrl[CTRL_EN_BIT];
   assign gif.sleep    = sleep;
   assign gif.div_sel  = st_r.ctrl[CTRL_DIV_LSB +: DIV_W];
   assign gif.duty_sel = st_r.ctrl[CTRL_DUTY_LSB +: DUTY_W];

   rcd_refclk_gen u_gen (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (rst_n),
      .gen     (gif)
   );

   // pin priority: crystal, then sysclk/4, then reference clock
   always_comb begin
      if (osc_mode != OSC_EXT) begin
         pin_oe = 1'h0;
         pin    = 1'h0;
      end else if (!st_r.cfg[CFG_CLKOUT_BIT]) begin
         pin_oe = 1'h1;
         pin    = st_r.fosc_cnt[1];
      end else begin
         pin_oe = st_r.ctrl[CTRL_OE_BIT];
         pin    = pin_oe & gif.ref_clk;
      end
   end

   assign REF_CLOCK_OUT_PIN_O        = pin;
   assign REF_CLOCK_OUT_PIN_OE_O     = pin_oe;
   assign REFCLK_SLEW_LIMIT_ENABLE_O = st_r.ctrl[CTRL_SLEW_BIT];
   assign MOD_CLK_O                  = gif.ref_clk;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!rst_n);

   AST_PIN_OE_FOLLOWS_BIT: assert property (
      osc_mode == OSC_EXT && st_r.cfg[CFG_CLKOUT_BIT] |-> REF_CLOCK_OUT_PIN_OE_O == st_r.ctrl[CTRL_OE_BIT])
      else $error("pin enable does not follow output enable bit");
   AST_SLEW_FOLLOWS_BIT: assert property (
      REFCLK_SLEW_LIMIT_ENABLE_O == st_r.ctrl[CTRL_SLEW_BIT])
      else $error("slew limit output does not follow control");
   AST_FOSC4_ON_PIN: assert property (
      osc_mode == OSC_EXT && !st_r.cfg[CFG_CLKOUT_BIT] && !sleep && st_r.fosc_cnt == 2'h1
      ##1 $stable(st_r.cfg) [*3]
      |-> !REF_CLOCK_OUT_PIN_O && $past(REF_CLOCK_OUT_PIN_O, 1) && $past(REF_CLOCK_OUT_PIN_O, 2)
          && $past(REF_CLOCK_OUT_PIN_OE_O, 3))
      else $error("sysclk/4 not on pin");
   AST_CRYSTAL_NO_DRIVE: assert property (
      osc_mode != OSC_EXT |-> !REF_CLOCK_OUT_PIN_OE_O)
      else $error("pin driven in crystal mode");
   AST_RESET_DEFAULTS: assert property (
      $rose(rst_n) |-> st_r.ctrl == CTRL_RST && !gif.run && !REF_CLOCK_OUT_PIN_OE_O)
      else $error("control not at defaults after reset");
   AST_ENABLE_STARTS: assert property (
      $rose(st_r.ctrl[CTRL_EN_BIT]) && !sleep ##1 !sleep |=> gif.run)
      else $error("generator did not start after enable");
   AST_DIV4_PERIOD: assert property (
      gif.run && !sleep && gif.div_sel == DIV_FOUR && gif.count == 7'h03 ##1 gif.count == 7'h00
      ##1 !sleep [*3] |-> gif.count == 7'h03)
      else $error("divide-by-four period wrong");
   AST_HALF_DUTY_DIV4: assert property (
      gif.run && gif.div_sel == DIV_FOUR && gif.duty_sel == 2'h2 && gif.count == 7'h00 && !sleep
      && $stable(gif.duty_sel) && $stable(gif.div_sel)
      ##1 gif.count == 7'h01 |-> gif.level ##1 !gif.level)
      else $error("fifty percent duty wrong at divide by four");
   AST_WRITE_RESPONDS: assert property (
      st_r.aw_got && st_r.w_got && !st_r.bvalid |=> S_AXI_BVALID_O)
      else $error("write response missing");
   AST_READ_RESPONDS: assert property (
      ar_hs |=> S_AXI_RVALID_O)
      else $error("read response missing");
endmodule : rcd_top

/* File: pkg/rcd_pkg.sv */
package rcd_pkg;
   // bus geometry
   localparam int unsigned ADDR_W        = 4;
   localparam int unsigned DATA_W        = 32;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CFG_OFS  = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STAT_OFS = 4'h8;

   // reference_clock_control fields
   localparam int unsigned CTRL_EN_BIT    = 7;
   localparam int unsigned CTRL_OE_BIT    = 6;
   localparam int unsigned CTRL_SLEW_BIT  = 5;
   localparam int unsigned CTRL_DUTY_LSB  = 3;
   localparam int unsigned CTRL_DIV_LSB   = 0;
   localparam logic [7:0]  CTRL_RST       = 8'h30;

   // configuration fields
   localparam int unsigned CFG_CLKOUT_BIT = 0;
   localparam int unsigned CFG_OSC_LSB    = 1;
   localparam int unsigned CFG_SLEEP_BIT  = 3;
   localparam logic [7:0]  CFG_RST        = 8'h01;
   localparam logic [1:0]  OSC_EXT        = 2'h0;
   localparam logic [1:0]  OSC_LP         = 2'h1;
   localparam logic [1:0]  OSC_XT         = 2'h2;
   localparam logic [1:0]  OSC_HS         = 2'h3;

   // divider and duty encodings
   localparam int unsigned CNT_W          = 7;
   localparam int unsigned DIV_W          = 3;
   localparam int unsigned DUTY_W         = 2;
   localparam logic [DIV_W-1:0]  DIV_ONE  = 3'h0;
   localparam logic [DIV_W-1:0]  DIV_TWO  = 3'h1;
   localparam logic [DIV_W-1:0]  DIV_FOUR = 3'h2;
   localparam logic [DUTY_W-1:0] DUTY_0   = 2'h0;
   localparam logic [DUTY_W-1:0] DUTY_25  = 2'h1;
   localparam logic [DUTY_W-1:0] DUTY_75  = 2'h3;
   localparam int unsigned FOSC4_CNT_W    = 2;

   function automatic logic [CNT_W-1:0] rcd_cnt_mask(input logic [DIV_W-1:0] div);
      logic [7:0] full;
      full = (8'h01 << div) - 8'h01;
      return full[CNT_W-1:0];
   endfunction : rcd_cnt_mask

   function automatic logic rcd_duty_high(input logic [CNT_W-1:0]  cnt,
                                          input logic [DIV_W-1:0]  div,
                                          input logic [DUTY_W-1:0] duty);
      logic [7:0] quarter;
      logic [7:0] thr;
      quarter = 8'h00;
      thr     = 8'h00;
      if (div == DIV_ONE) begin
         return duty != DUTY_0;
      end
      if (div == DIV_TWO) begin
         return (duty != DUTY_0) && !cnt[0];
      end
      quarter = 8'h01 << (div - DIV_FOUR);
      thr     = 8'(quarter * {6'h00, duty});
      return {1'h0, cnt} < thr;
   endfunction : rcd_duty_high
endpackage : rcd_pkg

/* File: pkg/rcd_gen_if.sv */
`timescale 1ns/10ps
interface rcd_gen_if;
   import rcd_pkg::*;
   logic                enable;
   logic                sleep;
   logic [DIV_W-1:0]    div_sel;
   logic [DUTY_W-1:0]   duty_sel;
   logic                ref_clk;
   logic                level;
   logic                run;
   logic [CNT_W-1:0]    count;

   modport ctl (output enable, sleep, div_sel, duty_sel, input ref_clk, level, run, count);
   modport gen (input enable, sleep, div_sel, duty_sel, output ref_clk, level, run, count);
endinterface : rcd_gen_if

/* File: src/rcd_refclk_gen.sv */
`timescale 1ns/10ps
module rcd_refclk_gen (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // settings and generated clock
   rcd_gen_if.gen    gen
);
   import rcd_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0]  cnt;
      logic [DIV_W-1:0]  div;
      logic [DUTY_W-1:0] duty;
      logic              run;
      logic              level;
   } rcd_gen_state_t;

   rcd_gen_state_t st_r;
   rcd_gen_state_t st_nxt;
   logic           wrap;
   logic           mix;

   always_comb begin
      st_nxt = st_r;
      wrap   = st_r.cnt == rcd_cnt_mask(st_r.div);
      if (gen.sleep) begin
         st_nxt = st_r;
      end else if (!gen.enable) begin
         st_nxt.run   = 1'h0;
         st_nxt.cnt   = '0;
         st_nxt.level = 1'h0;
         st_nxt.div   = gen.div_sel;
         st_nxt.duty  = gen.duty_sel;
      end else if (!st_r.run || wrap) begin
         // new settings only at a period boundary
         st_nxt.run   = 1'h1;
         st_nxt.cnt   = '0;
         st_nxt.div   = gen.div_sel;
         st_nxt.duty  = gen.duty_sel;
         st_nxt.level = rcd_duty_high('0, gen.div_sel, gen.duty_sel);
      end else begin
         st_nxt.cnt   = st_r.cnt + 7'h01;
         st_nxt.level = rcd_duty_high(st_r.cnt + 7'h01, st_r.div, st_r.duty);
      end
   end

   // system clock is the only base clock
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      mix = st_r.level;
      if (st_r.div == DIV_ONE) begin
         mix = st_r.level & clk_i;
      end else if (st_r.div == DIV_TWO && st_r.duty == DUTY_25) begin
         mix = st_r.level & clk_i;
      end else if (st_r.div == DIV_TWO && st_r.duty == DUTY_75) begin
         mix = st_r.run & (st_r.level | clk_i);
      end
      if (gen.sleep) begin
         mix = st_r.level;
      end
   end

   assign gen.ref_clk = mix;
   assign gen.level   = st_r.level;
   assign gen.run     = st_r.run;
   assign gen.count   = st_r.cnt;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_DISABLED_STOPS: assert property (
      !gen.enable && !gen.sleep |=> !st_r.run && !st_r.level && st_r.cnt == '0)
      else $error("disabled generator still running");
   AST_COUNT_WRAPS: assert property (
      st_r.run && gen.enable && !gen.sleep && wrap |=> st_r.cnt == '0)
      else $error("divider counter did not wrap at terminal count");
   AST_SETTINGS_AT_BOUNDARY: assert property (
      st_r.run && !wrap && gen.enable && !gen.sleep |=> $stable(st_r.div) && $stable(st_r.duty))
      else $error("divider settings changed mid period");
   AST_ZERO_DUTY_LOW: assert property (
      st_r.run && st_r.duty == DUTY_0 |-> !gen.ref_clk)
      else $error("zero duty setting produced a high output");
   AST_SLEEP_HOLDS: assert property (
      gen.sleep ##1 gen.sleep |-> $stable(st_r.level) && $stable(st_r.cnt) && $stable(gen.ref_clk))
      else $error("generator moved during sleep");
endmodule : rcd_refclk_gen

/* File: sim/rcd_pin_watch.sv */
`timescale 1ns/10ps
module rcd_pin_watch (
   // clock and observed pin
   input  wire logic clk_i,
   input  wire logic pin_i,
   input  wire logic oe_i,
   // last full period seen, in system clocks
   output int        hi_o,
   output int        per_o
);
   int   cnt;
   int   hc;
   logic prev;
   logic lvl;

   // an undriven pin reads low through the load's pull-down
   assign lvl = pin_i & oe_i;

   initial begin
      cnt   = 0;
      hc    = 0;
      prev  = 1'b0;
      hi_o  = 0;
      per_o = 0;
   end

   // sampled mid-cycle, where a registered pin is settled
   always @(negedge clk_i) begin
      cnt <= cnt + 1;
      if (lvl === 1'b1) begin
         hc <= hc + 1;
      end
      if (lvl === 1'b1 && prev !== 1'b1) begin
         per_o <= cnt;
         hi_o  <= hc;
         cnt   <= 1;
         hc    <= 1;
      end
      prev <= lvl;
   end
endmodule : rcd_pin_watch

/* File: sim/tb_rcd_top.sv */
`timescale 1ns/10ps
module tb_rcd_top;
   import rcd_pkg::*;
   logic        clk, nrst, awv, wv, bready, arv, rready;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, pin, oe, slew, mclk;
   logic [33:0] exp_q[$];
   logic [7:0]  rv;
   int          failures, num_checks, cycles, seed, hi, per, ph, nh, held;

   rcd_top u_dut (
      .SYS_CLK_I(clk), .NRST_I(nrst),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .REF_CLOCK_OUT_PIN_O(pin), .REF_CLOCK_OUT_PIN_OE_O(oe),
      .REFCLK_SLEW_LIMIT_ENABLE_O(slew), .MOD_CLK_O(mclk)
   );

   rcd_pin_watch u_watch (.clk_i(clk), .pin_i(pin), .oe_i(oe), .hi_o(hi), .per_o(per));

   always #20 clk = ~clk;

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         conclude();
      end
   end

   // response side: oldest note against each handshake
   always @(negedge clk) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
         check({bresp, 32'h0}, exp_q.pop_front());
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
         check({rresp, rdata}, exp_q.pop_front());
      end
   end

   // one bus transfer; w selects write, d is data written or expected
   task automatic xfer(input bit w, input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
      bit ga, gw, gb, da, dw, db;
      exp_q.push_back(w ? {r, 32'h0} : {r, 24'h0, d});
      @(posedge clk);
      if (w) begin
         awaddr <= a;
         wdata  <= {24'h0, d};
         awv    <= 1'b1;
         wv     <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a;
         arv    <= 1'b1;
         rready <= 1'b1;
      end
      da = 0;
      dw = !w;
      db = 0;
      while (!db) begin
         @(negedge clk);
         ga = !da && (w ? awready : arready);
         gw = !dw && wready;
         gb = w ? bvalid : rvalid;
         @(posedge clk);
         if (ga) begin
            awv <= 1'b0;
            arv <= 1'b0;
            da = 1;
         end
         if (gw) begin
            wv <= 1'b0;
            dw = 1;
         end
         if (gb) begin
            bready <= 1'b0;
            rready <= 1'b0;
            db = 1;
         end
      end
   endtask : xfer

   task automatic meas(input int p, input int h);
      repeat (3 * p + 260) @(posedge clk);
      check(34'(per), 34'(p));
      check(34'(hi), 34'(h));
   endtask : meas

   // high samples just after rising and falling edges over 8 cycles
   task automatic qcount(input bit m);
      ph = 0;
      nh = 0;
      repeat (8) begin
         @(posedge clk);
         #1;
         ph += ((m ? mclk : pin) === 1'b1);
         @(negedge clk);
         #1;
         nh += ((m ? mclk : pin) === 1'b1);
      end
   endtask : qcount

   initial begin
      {clk, nrst, awv, wv, bready, arv, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      seed = 54;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      check({33'h0, slew}, 34'h1);
      check({33'h0, oe}, 34'h0);
      xfer(0, REG_CTRL_OFS, CTRL_RST, RESP_OKAY);
      xfer(0, REG_CFG_OFS, CFG_RST, RESP_OKAY);
      xfer(1, 4'hC, 8'h00, RESP_SLVERR);
      xfer(0, 4'hC, 8'h00, RESP_SLVERR);
      rv = 8'($random(seed));
      rv[7] = 1'b0;
      xfer(1, REG_CTRL_OFS, rv, RESP_OKAY);
      xfer(0, REG_CTRL_OFS, rv, RESP_OKAY);
      repeat (2) @(posedge clk);
      check({33'h0, slew}, {33'h0, rv[5]});
      check({33'h0, oe}, {33'h0, rv[6]});
      $display("test registers done");
      for (int d = 2; d < 8; d++) begin
         for (int du = 1; du < 4; du++) begin
            xfer(1, REG_CTRL_OFS, {3'b111, 2'(du), 3'(d)}, RESP_OKAY);
            meas(1 << d, (1 << d) * du / 4);
         end
      end
      xfer(1, REG_CTRL_OFS, 8'hF1, RESP_OKAY);
      meas(2, 1);
      check({33'h0, oe}, 34'h1);
      xfer(1, REG_CTRL_OFS, 8'hE3, RESP_OKAY);
      repeat (300) @(posedge clk);
      qcount(0);
      check(34'(ph + nh), 34'h0);
      $display("test divider and duty done");
      for (int du = 0; du < 4; du++) begin
         xfer(1, REG_CTRL_OFS, {3'b111, 2'(du), 3'(du == 0 ? 0 : 1)}, RESP_OKAY);
         repeat (10) @(posedge clk);
         qcount(0);
         check(34'(ph), du == 0 ? 34'h0 : du == 1 ? 34'h4 : du == 2 ? 34'h4 : 34'h8);
         check(34'(nh), du == 3 ? 34'h4 : du == 2 ? 34'h4 : 34'h0);
      end
      xfer(1, REG_CTRL_OFS, 8'hD0, RESP_OKAY);
      repeat (10) @(posedge clk);
      qcount(0);
      check(34'(ph), 34'h8);
      check(34'(nh), 34'h0);
      $display("test undivided modes done");
      xfer(1, REG_CFG_OFS, 8'h00, RESP_OKAY);
      xfer(1, REG_CTRL_OFS, 8'hB1, RESP_OKAY);
      meas(4, 2);
      check({33'h0, oe}, 34'h1);
      for (int m = 1; m < 4; m++) begin
         xfer(1, REG_CFG_OFS, {5'h0, 2'(m), 1'b1}, RESP_OKAY);
         repeat (2) @(posedge clk);
         check({33'h0, oe}, 34'h0);
         qcount(1);
         check(34'(ph + nh), 34'h8);
      end
      $display("test pin conflicts done");
      xfer(1, REG_CFG_OFS, 8'h01, RESP_OKAY);
      xfer(1, REG_CTRL_OFS, 8'hD3, RESP_OKAY);
      repeat (40) @(posedge clk);
      xfer(1, REG_CFG_OFS, 8'h09, RESP_OKAY);
      repeat (2) @(posedge clk);
      held = int'(pin === 1'b1);
      qcount(0);
      check(34'(ph + nh), 34'(16 * held));
      xfer(1, REG_CFG_OFS, 8'h01, RESP_OKAY);
      xfer(1, REG_CTRL_OFS, 8'h53, RESP_OKAY);
      repeat (4) @(posedge clk);
      qcount(0);
      check(34'(ph + nh), 34'h0);
      qcount(1);
      check(34'(ph + nh), 34'h0);
      $display("test sleep and disable done");
      xfer(1, REG_CTRL_OFS, 8'hC2, RESP_OKAY);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      check({33'h0, oe}, 34'h0);
      xfer(0, REG_CTRL_OFS, CTRL_RST, RESP_OKAY);
      $display("test second reset done");
      conclude();
   end
endmodule : tb_rcd_top
